// [design/cfgss_lock_gate.v]
// lock qualifier for the de-skew loops
// assumes lock inputs synchronous to configuration_clock
`timescale 1ns/1ps
`include "cfgss_map.vh"

module cfgss_lock_gate (
  loop_locked,
  loop_select,
  need_all,
  lock_ok
);
  input  wire [`CFGSS_NUM_LOOPS-1:0] loop_locked;
  input  wire [`CFGSS_NUM_LOOPS-1:0] loop_select;
  input  wire                        need_all;
  output wire                        lock_ok;

  wire [`CFGSS_NUM_LOOPS-1:0] hit;

  assign hit = loop_locked & loop_select;
  // no loops chosen means nothing to wait for
  assign lock_ok = (loop_select == {`CFGSS_NUM_LOOPS{1'b0}}) ? 1'b1 :
                   need_all ? (hit == loop_select) : (|hit);
endmodule

// [design/cfgss_map.vh]
// constants of the configuration start-up sequencer
// assumes inclusion by design files that use the cycle numbering below
`ifndef CFGSS_MAP_VH
`define CFGSS_MAP_VH

// ****************************************************************
// start-up cycle numbering
// ****************************************************************
`define CFGSS_CYC_W        3
`define CFGSS_CYC_LAST     3'h7
// default positions: cycle 0 is the completion rise
`define CFGSS_DEF_FLOAT    3'h1
`define CFGSS_DEF_PRESET   3'h2
`define CFGSS_DEF_PERMIT   3'h2
`define CFGSS_DEF_DONE     3'h0

// ****************************************************************
// clear phase length
// ****************************************************************
`define CFGSS_CLEAR_W      4
`define CFGSS_CLEAR_CYCLES 4'hF

// ****************************************************************
// de-skew loops
// ****************************************************************
`define CFGSS_NUM_LOOPS    4

`endif

// [design/cfgss_top.v]
// start-up sequencer: clear, load, then staged release of globals
// assumes all inputs synchronous to configuration_clock, sync reset
`timescale 1ns/1ps
`include "cfgss_map.vh"

module cfgss_top (
  ref_clk,
  reset,
  reconfig_req_n,
  clear_status_in,
  load_done,
  done_in,
  sync_done_en,
  pos_float,
  pos_preset,
  pos_permit,
  pos_done,
  lock_stage,
  loop_select,
  loop_need_all,
  loop_locked,
  clear_status_out,
  clear_status_oe,
  clearing,
  loading,
  done_out,
  done_oe,
  global_output_float,
  global_preset_clear,
  global_write_permit,
  startup_active
);
  input  wire                        ref_clk;
  input  wire                        reset;
  input  wire                        reconfig_req_n;
  input  wire                        clear_status_in;
  input  wire                        load_done;
  input  wire                        done_in;
  input  wire                        sync_done_en;
  input  wire [`CFGSS_CYC_W-1:0]     pos_float;
  input  wire [`CFGSS_CYC_W-1:0]     pos_preset;
  input  wire [`CFGSS_CYC_W-1:0]     pos_permit;
  input  wire [`CFGSS_CYC_W-1:0]     pos_done;
  input  wire [`CFGSS_CYC_W-1:0]     lock_stage;
  input  wire [`CFGSS_NUM_LOOPS-1:0] loop_select;
  input  wire                        loop_need_all;
  input  wire [`CFGSS_NUM_LOOPS-1:0] loop_locked;
  output reg                         clear_status_out;
  output reg                         clear_status_oe;
  output reg                         clearing;
  output reg                         loading;
  output reg                         done_out;
  output reg                         done_oe;
  output reg                         global_output_float;
  output reg                         global_preset_clear;
  output reg                         global_write_permit;
  output reg                         startup_active;

  // ****************************************************************
  // states
  // ****************************************************************
  localparam [4:0] ST_CLEAR = 5'h01;
  localparam [4:0] ST_WAIT  = 5'h02;
  localparam [4:0] ST_LOAD  = 5'h04;
  localparam [4:0] ST_START = 5'h08;
  localparam [4:0] ST_RUN   = 5'h10;

  reg [4:0]                  state_ff;
  reg [4:0]                  nxt_state;
  reg [`CFGSS_CLEAR_W-1:0]   clr_cnt_ff;
  reg [`CFGSS_CLEAR_W-1:0]   nxt_clr_cnt;
  reg [`CFGSS_CYC_W-1:0]     cyc_ff;
  reg [`CFGSS_CYC_W-1:0]     nxt_cyc;
  reg                        float_rel_ff;
  reg                        preset_rel_ff;
  reg                        permit_rel_ff;
  reg                        done_rel_ff;
  reg                        nxt_float_rel;
  reg                        nxt_preset_rel;
  reg                        nxt_permit_rel;
  reg                        nxt_done_rel;
  wire                       lock_ok;
  wire                       advance;
  wire                       shared_ok;

  function reached;
    input [`CFGSS_CYC_W-1:0] cyc;
    input [`CFGSS_CYC_W-1:0] pos;
    begin
      reached = (cyc >= pos);
    end
  endfunction

  cfgss_lock_gate u_lock (
    .loop_locked (loop_locked),
    .loop_select (loop_select),
    .need_all    (loop_need_all),
    .lock_ok     (lock_ok)
  );

  // ****************************************************************
  // start-up stepping
  // ****************************************************************
  // stall at chosen stage
  assign advance = (cyc_ff != lock_stage) | lock_ok;
  assign shared_ok = ~sync_done_en | done_in;

  always @* begin
    nxt_state      = state_ff;
    nxt_clr_cnt    = clr_cnt_ff;
    nxt_cyc        = cyc_ff;
    nxt_float_rel  = float_rel_ff;
    nxt_preset_rel = preset_rel_ff;
    nxt_permit_rel = permit_rel_ff;
    nxt_done_rel   = done_rel_ff;
    case (state_ff)
      ST_CLEAR: begin
        nxt_clr_cnt = clr_cnt_ff + 1'b1;
        if (clr_cnt_ff == `CFGSS_CLEAR_CYCLES) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (clear_status_in) begin
          nxt_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (load_done) begin
          nxt_state = ST_START;
          nxt_cyc   = {`CFGSS_CYC_W{1'b0}};
        end
      end
      ST_START: begin
        if (reached(cyc_ff, pos_done)) begin
          nxt_done_rel = 1'b1;
        end
        if (reached(cyc_ff, pos_float) && shared_ok) begin
          nxt_float_rel = 1'b1;
        end
        if (reached(cyc_ff, pos_preset) && shared_ok) begin
          nxt_preset_rel = 1'b1;
        end
        if (reached(cyc_ff, pos_permit) && shared_ok) begin
          nxt_permit_rel = 1'b1;
        end
        if (advance && cyc_ff != `CFGSS_CYC_LAST) begin
          nxt_cyc = cyc_ff + 1'b1;
        end
        if (float_rel_ff && preset_rel_ff && permit_rel_ff &&
            done_rel_ff) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_CLEAR;
      end
    endcase
    if (!reconfig_req_n) begin
      nxt_state      = ST_CLEAR;
      nxt_clr_cnt    = {`CFGSS_CLEAR_W{1'b0}};
      nxt_cyc        = {`CFGSS_CYC_W{1'b0}};
      nxt_float_rel  = 1'b0;
      nxt_preset_rel = 1'b0;
      nxt_permit_rel = 1'b0;
      nxt_done_rel   = 1'b0;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always @(posedge ref_clk) begin
    if (reset) begin
      state_ff      <= ST_CLEAR;
      clr_cnt_ff    <= {`CFGSS_CLEAR_W{1'b0}};
      cyc_ff        <= {`CFGSS_CYC_W{1'b0}};
      float_rel_ff  <= 1'b0;
      preset_rel_ff <= 1'b0;
      permit_rel_ff <= 1'b0;
      done_rel_ff   <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      clr_cnt_ff    <= nxt_clr_cnt;
      cyc_ff        <= nxt_cyc;
      float_rel_ff  <= nxt_float_rel;
      preset_rel_ff <= nxt_preset_rel;
      permit_rel_ff <= nxt_permit_rel;
      done_rel_ff   <= nxt_done_rel;
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always @(posedge ref_clk) begin
    if (reset) begin
      clear_status_out    <= 1'b0;
      clear_status_oe     <= 1'b1;
      clearing            <= 1'b1;
      loading             <= 1'b0;
      done_out            <= 1'b0;
      done_oe             <= 1'b1;
      global_output_float <= 1'b1;
      global_preset_clear <= 1'b1;
      global_write_permit <= 1'b0;
      startup_active      <= 1'b0;
    end else begin
      clear_status_out    <= 1'b0;
      clear_status_oe     <= (nxt_state == ST_CLEAR);
      clearing            <= (nxt_state == ST_CLEAR);
      loading             <= (nxt_state == ST_LOAD);
      done_out            <= 1'b0;
      done_oe             <= ~nxt_done_rel;
      global_output_float <= ~nxt_float_rel;
      global_preset_clear <= ~nxt_preset_rel;
      global_write_permit <= nxt_permit_rel;
      startup_active      <= (nxt_state == ST_START);
    end
  end
endmodule

// [test/cfgss_far_end.sv]
// far end: loader, peer devices, open-drain wires
// both wires pulled up; bench sets the holds
`timescale 1ns/1ps
module cfgss_far_end (
  input  wire logic       ref_clk, clear_status_oe, done_oe, loading,
  input  wire logic       hold_clear, hold_done, clear_status_out, done_out,
  input  wire logic [3:0] load_wait,
  output wire logic       clear_status_in, done_in, load_done
);
  logic [3:0] cnt_ff = 4'h0;
  logic       fin_ff = 1'h0;
  assign clear_status_in = !((clear_status_oe && !clear_status_out)
                             || hold_clear);
  assign done_in = !((done_oe && !done_out) || hold_done);
  assign load_done = fin_ff;
  // loader ends load_wait+1 cycles after loading rises
  always @(posedge ref_clk) begin
    cnt_ff <= loading ? cnt_ff + 4'h1 : 4'h0;
    fin_ff <= loading && cnt_ff == load_wait;
  end
endmodule

// [test/cfgss_monitor.sv]
// checker on the sequencer ports
// bound to cfgss_top by the bench
`timescale 1ns/1ps
module cfgss_monitor (
  input wire logic       ref_clk, reset, reconfig_req_n, clear_status_in,
  input wire logic       load_done, done_in, sync_done_en, loading, clearing,
  input wire logic       clear_status_oe, done_oe, global_output_float,
  input wire logic       global_preset_clear, global_write_permit,
  input wire logic       loop_need_all,
  input wire logic [2:0] pos_float, pos_permit, lock_stage,
  input wire logic [3:0] loop_select, loop_locked
);
  // **
  // cycles since load end
  // **
  logic [3:0] cyc_ff;
  logic       free, lk, held;
  assign free = !sync_done_en && loop_select == 4'h0;
  assign lk = loop_need_all ? &(loop_locked | ~loop_select)
                            : |(loop_locked & loop_select);
  assign held = global_output_float && global_preset_clear
                && !global_write_permit;
  always_ff @(posedge ref_clk)
    if (reset || (loading && load_done)) cyc_ff <= 4'h0;
    else if (cyc_ff != 4'hF) cyc_ff <= cyc_ff + 4'h1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  init_drive_a:
    assert property ($fell(reset) |-> clear_status_oe [*8])
    else $error("clear not driven");
  load_stall_a:
    assert property (!loading && !clear_status_in |=> !loading)
    else $error("early load");
  float_cycle_a:
    assert property (free && $fell(global_output_float) |->
      cyc_ff == pos_float + 4'h1) else $error("float cycle");
  permit_cycle_a:
    assert property (free && $rose(global_write_permit) |->
      cyc_ff == pos_permit + 4'h1) else $error("permit cycle");
  sync_hold_a:
    assert property (sync_done_en && !done_in && global_output_float
      |=> global_output_float) else $error("float before done");
  lock_hold_a:
    assert property (loop_select != 4'h0 && !lk && lock_stage == 3'h0
      && pos_float != 3'h0 && global_output_float |=> global_output_float)
    else $error("float before lock");
  phase_order_a:
    assert property (loading |-> !clearing && !clear_status_oe && held)
    else $error("phase overlap");
  restart_hold_a:
    assert property (!reconfig_req_n |=> clear_status_oe && held)
    else $error("no restart");
endmodule

// [test/tb_top.sv]
// bench top: sequencer, far-end model, checker bind
// needs the design header on the include path
`timescale 1ns/1ps
`include "cfgss_map.vh"
module tb_top;
  logic       ref_clk = 1'h0, reset = 1'h1, reconfig_req_n = 1'h1;
  logic       sync_done_en = 1'h0, loop_need_all = 1'h0, hold_clear = 1'h0;
  logic       hold_done = 1'h0, clear_status_in, done_in, load_done;
  logic       clear_status_out, clear_status_oe, clearing, loading;
  logic       done_out, done_oe, global_output_float, startup_active;
  logic       global_preset_clear, global_write_permit;
  logic [2:0] pos_float, pos_preset, pos_permit, pos_done;
  logic [2:0] lock_stage = 3'h0;
  logic [3:0] loop_select = 4'h0, loop_locked = 4'h0, load_wait = 4'h3;
  int         num_errors = 0, check_count = 0, cyc = 0, t0, tf, tp, tw, td;
  cfgss_top     dut (.*);
  cfgss_far_end far (.*);
  always #2.5 ref_clk = ~ref_clk;
  // **
  // last cycle before each release
  // **
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (loading && load_done) t0 <= cyc;
    if (global_output_float) tf <= cyc;
    if (global_preset_clear) tp <= cyc;
    if (!global_write_permit) tw <= cyc;
    if (done_oe) td <= cyc;
    if (cyc == 3000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic clk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic restart();
    {reconfig_req_n, hold_clear} = 2'h1;
    clk(2);
    reconfig_req_n = 1'h1;
    chk({clear_status_oe, global_output_float, global_preset_clear,
         global_write_permit, clear_status_out, done_out}, 8'h38);
    clk(30);
    chk(loading, 1'h0);
    hold_clear = 1'h0;
    for (int i = 0; i < 40 && loading !== 1'h1; i++) clk(1);
    chk({loading, clear_status_oe, clear_status_in}, 8'h5);
  endtask
  task automatic seq(input logic [2:0] f, p, w);
    {pos_float, pos_preset, pos_permit} = {f, p, w};
    restart();
    clk(20);
    chk(8'(tf - t0 - 1), f);
    chk(8'(tp - t0 - 1), p);
    chk(8'(tw - t0 - 1), w);
    chk(8'(td - t0 - 1), pos_done);
    chk(startup_active, 1'h0);
  endtask
  task automatic stall(input logic s, input logic [3:0] sel, lck);
    // float must sit past the stall stage to show the hold
    {pos_float, pos_preset, pos_permit} = {`CFGSS_DEF_FLOAT,
      `CFGSS_DEF_PRESET, `CFGSS_DEF_PERMIT};
    {sync_done_en, hold_done, loop_need_all} = {s, s, !s};
    {loop_select, loop_locked} = {sel, lck};
    restart();
    clk(20);
    chk({global_output_float, startup_active}, 8'h3);
    {hold_done, loop_need_all} = 2'h0;
    clk(20);
    chk({global_output_float, global_write_permit,
         startup_active}, 8'h2);
    {sync_done_en, loop_select} = 5'h0;
    clk(1);
  endtask
  task automatic power_up();
    clk(16);
    reset = 1'h0;
    chk({clear_status_oe, clearing, global_output_float,
         global_preset_clear, global_write_permit, done_oe}, 8'h3D);
    clk(60);
  endtask
  initial begin
    {pos_float, pos_preset, pos_permit, pos_done} = {`CFGSS_DEF_FLOAT,
      `CFGSS_DEF_PRESET, `CFGSS_DEF_PERMIT, `CFGSS_DEF_DONE};
    power_up();
    seq(`CFGSS_DEF_FLOAT, `CFGSS_DEF_PRESET, `CFGSS_DEF_PERMIT);
    seq(3'h4, 3'h0, 3'h6);
    load_wait = 4'h0;
    seq(3'h0, 3'h7, 3'h3);
    stall(1'h1, 4'h0, 4'h0);
    stall(1'h0, 4'h3, 4'h1);
    wrap_up();
  end
endmodule
bind cfgss_top cfgss_monitor mon (.*);
